// File: hw/ccd_readout_sequencer.sv
// Purpose: Timing generator that exposes and reads out a full-frame two-phase CCD.
// Assumes: Analog sampling electronics act on sample strobes; shutter follows shutter_open.
// Notes: One frame per start pulse; start is ignored while busy, except in the cycle frame_done is high, when it begins the next frame.
`timescale 1ns/1ps
module ccd_readout_sequencer #(
    parameter int unsigned COLUMNS = ccd_pkg::CCD_HREG_LEN,
    parameter int unsigned LINES   = ccd_pkg::CCD_LINES
) (
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                start,
    input  wire logic [31:0]         expose_cycles,
    output logic                     vertical_phase_one,
    output logic                     vertical_phase_two,
    output logic                     horizontal_phase_one,
    output logic                     horizontal_phase_two,
    output logic                     reset_gate,
    output logic                     shutter_open,
    output logic                     sample_ref,
    output logic                     sample_sig,
    output ccd_pkg::ccd_class_e      pixel_class,
    output logic [10:0]              pixel_index,
    output logic [10:0]              line_index,
    output logic                     busy,
    output logic                     frame_done
);
    import ccd_pkg::*;

    ccd_state_e  state;
    logic [31:0] timer;
    logic [31:0] expose_count;
    logic [10:0] pix;
    logic [10:0] lin;
    logic [31:0] expose_len;

    ccd_pos_if pos ();
    assign pos.pixel = pix;
    assign pos.line  = lin;

    ccd_classify u_classify (
        .pos (pos.cls_end)
    );

    // A single down-counter times every readout phase, so all readout widths come from one place.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state      <= CCD_IDLE;
            timer      <= 32'h0;
            pix        <= 11'h0;
            lin        <= 11'h0;
            expose_len <= CCD_EXPOSE_RESET;
        end else begin
            if (timer != 32'h0) begin
                timer <= timer - 32'h1;
            end else begin
                unique case (state)
                    CCD_IDLE: begin
                        if (start) begin
                            // A zero length would wrap the compare to the full 32-bit count, so it is taken as one cycle.
                            expose_len <= (expose_cycles == 32'h0) ? 32'h1 : expose_cycles;
                            lin        <= 11'h0;
                            state      <= CCD_EXPOSE;
                        end
                    end
                    CCD_EXPOSE: begin
                        if (expose_count == expose_len - 32'h1) begin
                            timer <= 32'(CCD_VPHASE_CYC - 1);
                            state <= CCD_V1_HIGH;
                        end
                    end
                    CCD_V1_HIGH: begin
                        timer <= 32'(CCD_VPHASE_CYC - 1);
                        state <= CCD_V2_HIGH;
                    end
                    CCD_V2_HIGH: begin
                        timer <= 32'(CCD_VPHASE_CYC - 1);
                        state <= CCD_V1_LOW;
                    end
                    CCD_V1_LOW: begin
                        timer <= 32'(CCD_VPHASE_CYC - 1);
                        state <= CCD_V2_LOW;
                    end
                    CCD_V2_LOW: begin
                        pix   <= 11'h0;
                        timer <= 32'(CCD_RST_CYC - 1);
                        state <= CCD_H_RESET;
                    end
                    CCD_H_RESET: begin
                        timer <= 32'(CCD_SETTLE_CYC - 1);
                        state <= CCD_H_REFSMP;
                    end
                    CCD_H_REFSMP: begin
                        timer <= 32'(CCD_HPHASE_CYC - 1);
                        state <= CCD_H_SHIFT;
                    end
                    CCD_H_SHIFT: begin
                        // The packet moves as phase two falls, so the signal sample waits one settle time.
                        timer <= 32'(CCD_SETTLE_CYC - 1);
                        state <= CCD_H_SIGSMP;
                    end
                    CCD_H_SIGSMP: begin
                        if (pix == 11'(COLUMNS - 1)) begin
                            if (lin == 11'(LINES - 1)) begin
                                state <= CCD_DONE;
                            end else begin
                                lin   <= lin + 11'h1;
                                timer <= 32'(CCD_VPHASE_CYC - 1);
                                state <= CCD_V1_HIGH;
                            end
                        end else begin
                            pix   <= pix + 11'h1;
                            timer <= 32'(CCD_RST_CYC - 1);
                            state <= CCD_H_RESET;
                        end
                    end
                    CCD_DONE: begin
                        state <= CCD_IDLE;
                    end
                    default: begin
                        state <= CCD_IDLE;
                    end
                endcase
            end
        end
    end

    // Exposure is counted apart from the phase timer, against the length latched at start.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            expose_count <= 32'h0;
        end else if (state == CCD_EXPOSE) begin
            expose_count <= expose_count + 32'h1;
        end else begin
            expose_count <= 32'h0;
        end
    end

    // Vertical clocks: low in idle and exposure, stepped V1 up, V2 up, V1 down, V2 down.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vertical_phase_one <= 1'b0;
            vertical_phase_two <= 1'b0;
        end else begin
            vertical_phase_one <= (state == CCD_V1_HIGH || state == CCD_V2_HIGH);
            vertical_phase_two <= (state == CCD_V2_HIGH || state == CCD_V1_LOW);
        end
    end

    // Horizontal phase one idles high so the line lands in the register as V2 falls.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            horizontal_phase_one <= 1'b1;
            horizontal_phase_two <= 1'b0;
        end else begin
            // Phase two is high only while shifting; reset and both samples see it low.
            horizontal_phase_one <= (state != CCD_H_SHIFT);
            horizontal_phase_two <= (state == CCD_H_SHIFT);
        end
    end

    // Reset gate fires only after the previous signal sample, then a reference sample follows.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reset_gate <= 1'b0;
            sample_ref <= 1'b0;
            sample_sig <= 1'b0;
        end else begin
            reset_gate <= (state == CCD_H_RESET);
            sample_ref <= (state == CCD_H_REFSMP) && (timer == 32'h0);
            sample_sig <= (state == CCD_H_SIGSMP) && (timer == 32'h0);
        end
    end

    // The shutter is open strictly inside exposure; readout is always dark.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shutter_open <= 1'b0;
        end else begin
            shutter_open <= (state == CCD_EXPOSE);
        end
    end

    // Class and indices share one register stage so they always name the same pixel.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pixel_class <= CCD_CLS_DUMMY;
            pixel_index <= 11'h0;
            line_index  <= 11'h0;
        end else begin
            pixel_class <= pos.cls;
            pixel_index <= pix;
            line_index  <= lin;
        end
    end

    // Frame status; the done pulse lasts one cycle because the done state has no timer.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy       <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            busy       <= (state != CCD_IDLE);
            frame_done <= (state == CCD_DONE);
        end
    end
endmodule : ccd_readout_sequencer

// File: shared/ccd_pkg.sv
// Purpose: Shared constants and types for the sensor readout timing controller.
// Assumes: 125 MHz system clock; sensor geometry as built into the sensor itself.
// Notes: Phase widths are in clock cycles, except the vertical phase, which is set in ns and rounded up to cycles; all may be tuned for the analog front end.
package ccd_pkg;
    localparam int unsigned CCD_COLUMNS      = 1552;
    localparam int unsigned CCD_LINES        = 1032;
    localparam int unsigned CCD_HREG_LEN     = 1564;
    localparam int unsigned CCD_LEAD_DARK    = 4;
    localparam int unsigned CCD_TRAIL_DARK   = 12;
    localparam int unsigned CCD_DARK_LINES   = 4;
    localparam int unsigned CCD_LEAD_DUMMY   = 10;
    localparam int unsigned CCD_TRAIL_DUMMY  = 2;
    localparam int unsigned CCD_CLK_NS       = 8;
    localparam int unsigned CCD_VPHASE_NS    = 2000;
    localparam int unsigned CCD_VPHASE_CYC   = (CCD_VPHASE_NS + CCD_CLK_NS - 1) / CCD_CLK_NS;
    localparam int unsigned CCD_HPHASE_CYC   = 8;
    localparam int unsigned CCD_RST_CYC      = 2;
    localparam int unsigned CCD_SETTLE_CYC   = 2;
    localparam logic [31:0] CCD_EXPOSE_RESET = 32'h0001_0000;

    typedef enum logic [3:0] {
        CCD_IDLE     = 4'h0,
        CCD_EXPOSE   = 4'h1,
        CCD_V1_HIGH  = 4'h2,
        CCD_V2_HIGH  = 4'h3,
        CCD_V1_LOW   = 4'h4,
        CCD_V2_LOW   = 4'h5,
        CCD_H_RESET  = 4'h6,
        CCD_H_REFSMP = 4'h7,
        CCD_H_SHIFT  = 4'h8,
        CCD_H_SIGSMP = 4'h9,
        CCD_DONE     = 4'ha
    } ccd_state_e;

    typedef enum logic [1:0] {
        CCD_CLS_ACTIVE = 2'h0,
        CCD_CLS_DARK   = 2'h1,
        CCD_CLS_DUMMY  = 2'h2
    } ccd_class_e;
endpackage : ccd_pkg

// File: shared/ccd_pos_if.sv
// Purpose: Carries pixel and line positions between the sequencer and its classifier.
// Assumes: Both ends sit on the same clock.
// Notes: Classification is purely combinational.
`timescale 1ns/1ps
interface ccd_pos_if;
    logic [10:0]          pixel;
    logic [10:0]          line;
    ccd_pkg::ccd_class_e  cls;
    modport seq (output pixel, output line, input cls);
    modport cls_end (input pixel, input line, output cls);
endinterface : ccd_pos_if

// File: hw/ccd_classify.sv
// Purpose: Labels each pixel position as dummy, dark reference or active.
// Assumes: Pixel index counts horizontal register outputs from zero.
// Notes: Dark pixels next to active ones may carry signal; software must not treat them as true dark.
`timescale 1ns/1ps
module ccd_classify (
    ccd_pos_if.cls_end pos
);
    import ccd_pkg::*;

    always_comb begin
        if (pos.pixel < 11'(CCD_LEAD_DUMMY) ||
            pos.pixel >= 11'(CCD_LEAD_DUMMY + CCD_COLUMNS)) begin
            pos.cls = CCD_CLS_DUMMY;
        end else if (pos.pixel < 11'(CCD_LEAD_DUMMY + CCD_LEAD_DARK) ||
                     pos.pixel >= 11'(CCD_LEAD_DUMMY + CCD_COLUMNS - CCD_TRAIL_DARK) ||
                     pos.line < 11'(CCD_DARK_LINES) ||
                     pos.line >= 11'(CCD_LINES - CCD_DARK_LINES)) begin
            pos.cls = CCD_CLS_DARK;
        end else begin
            pos.cls = CCD_CLS_ACTIVE;
        end
    end
endmodule : ccd_classify

// File: dv/ccd_sensor_model.sv
// Purpose: Behavioural sensor that loads lines, shifts packets and drives a video level.
// Assumes: Phases come from the sequencer; one output amplifier.
// Notes: Charge is the packet number modulo 256 plus one, so it is never zero, and a missed reset shows at the sample.
`timescale 1ns/1ps
module ccd_sensor_model (
    input  wire logic   clk,
    input  wire logic   vertical_phase_two,
    input  wire logic   horizontal_phase_one,
    input  wire logic   horizontal_phase_two,
    input  wire logic   reset_gate,
    output logic [15:0] video,
    output int          lines_out,
    output int          pix_out
);
    logic        v2_q   = 1'b0;
    logic        h2_q   = 1'b0;
    logic [15:0] charge = 16'h0000;
    initial lines_out = 0;
    initial pix_out = 0;
    always @(posedge clk) begin
        v2_q <= vertical_phase_two;
        h2_q <= horizontal_phase_two;
        if (v2_q && !vertical_phase_two && horizontal_phase_one) lines_out <= lines_out + 1;
        if (h2_q && !horizontal_phase_two) begin
            pix_out <= pix_out + 1;
            charge <= 16'(pix_out[7:0]) + 16'h0001;
        end else if (reset_gate) charge <= 16'h0000;
    end
    assign video = 16'hffff - charge;
endmodule : ccd_sensor_model

// File: dv/ccd_readout_sequencer_sva.sv
// Purpose: Timing checks on the sequencer's sensor clocks and strobes.
// Assumes: Reset gate two cycles wide, settle two cycles.
// Notes: Sample windows allow a little slack around the settle time.
`timescale 1ns/1ps
module ccd_readout_sequencer_sva (
    input wire logic clk,
    input wire logic resetn,
    input wire logic vertical_phase_one,
    input wire logic vertical_phase_two,
    input wire logic horizontal_phase_one,
    input wire logic horizontal_phase_two,
    input wire logic reset_gate,
    input wire logic shutter_open,
    input wire logic sample_ref,
    input wire logic sample_sig,
    input wire logic busy,
    input wire logic frame_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_v_low; shutter_open |-> !vertical_phase_one && !vertical_phase_two; endproperty
    a_v_low: assert property (p_v_low) else $error("vertical phase high in exposure");
    property p_dark; (vertical_phase_one || vertical_phase_two || horizontal_phase_two) |-> !shutter_open; endproperty
    a_dark: assert property (p_dark) else $error("shutter open in readout");
    property p_load; $fell(vertical_phase_two) |-> horizontal_phase_one; endproperty
    a_load: assert property (p_load) else $error("line loaded with h1 low");
    property p_compl; horizontal_phase_one != horizontal_phase_two; endproperty
    a_compl: assert property (p_compl) else $error("h phases not complementary");
    property p_rg_width; $rose(reset_gate) |=> reset_gate ##1 !reset_gate; endproperty
    a_rg_width: assert property (p_rg_width) else $error("reset gate width wrong");
    property p_ref; $fell(reset_gate) |-> ##[0:3] sample_ref; endproperty
    a_ref: assert property (p_ref) else $error("no reference sample after reset");
    property p_sig; $fell(horizontal_phase_two) |-> ##[0:3] sample_sig; endproperty
    a_sig: assert property (p_sig) else $error("no signal sample after transfer");
    property p_busy; $rose(busy) |-> shutter_open; endproperty
    a_busy: assert property (p_busy) else $error("frame began without exposure");
    property p_done; frame_done |-> ##[0:2] !busy; endproperty
    a_done: assert property (p_done) else $error("busy after frame end");
    c_done: cover property (frame_done);
    c_load: cover property ($fell(vertical_phase_two));
    c_sig: cover property (sample_sig);
endmodule : ccd_readout_sequencer_sva

// File: dv/test_ccd_readout_sequencer.sv
// Purpose: Self-checking bench for the readout sequencer against a behavioural sensor.
// Assumes: Shortened to 20 pixels by 6 lines; classification keeps the full geometry.
// Notes: An exposure length of zero is expected to open the shutter for one cycle.
`timescale 1ns/1ps
module test_ccd_readout_sequencer;
    import ccd_pkg::*;
    localparam int unsigned COLS = 20;
    localparam int unsigned LNS  = 6;
    logic        clk = 1'b0, resetn = 1'b0, start = 1'b0;
    logic [31:0] expose_cycles = 32'h0;
    logic        vertical_phase_one, vertical_phase_two, horizontal_phase_one, horizontal_phase_two;
    logic        reset_gate, shutter_open, sample_ref, sample_sig, busy, frame_done;
    ccd_class_e  pixel_class;
    logic [10:0] pixel_index, line_index;
    logic [15:0] video;
    int          lines_out, pix_out, n_fail = 0, checks = 0, shut_n = 0, sig_n = 0;
    logic        ref_pend = 1'b0;
    always #4 clk = ~clk;
    ccd_readout_sequencer #(.COLUMNS(COLS), .LINES(LNS)) u_ccd_readout_sequencer (.clk, .resetn, .start,
        .expose_cycles, .vertical_phase_one, .vertical_phase_two, .horizontal_phase_one, .horizontal_phase_two,
        .reset_gate, .shutter_open, .sample_ref, .sample_sig, .pixel_class, .pixel_index, .line_index, .busy,
        .frame_done);
    ccd_sensor_model u_ccd_sensor_model (.clk, .vertical_phase_two, .horizontal_phase_one, .horizontal_phase_two,
        .reset_gate, .video, .lines_out, .pix_out);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic results;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    function automatic ccd_class_e exp_cls(input logic [10:0] p, input logic [10:0] l);
        if (p < CCD_LEAD_DUMMY || p >= CCD_HREG_LEN - CCD_TRAIL_DUMMY) return CCD_CLS_DUMMY;
        if (p < CCD_LEAD_DUMMY + CCD_LEAD_DARK || p >= CCD_HREG_LEN - CCD_TRAIL_DUMMY - CCD_TRAIL_DARK ||
            l < CCD_DARK_LINES || l >= CCD_LINES - CCD_DARK_LINES) return CCD_CLS_DARK;
        return CCD_CLS_ACTIVE;
    endfunction : exp_cls
    always @(posedge clk) begin
        if (resetn && shutter_open === 1'b1) shut_n++;
        if (resetn && sample_ref === 1'b1) begin
            check(32'(video), 32'h0000ffff);
            ref_pend = 1'b1;
        end
        if (resetn && sample_sig === 1'b1) begin
            check(32'(ref_pend), 32'h1);
            check(32'(video == 16'hffff), 32'h0);
            check(32'(pixel_class), 32'(exp_cls(pixel_index, line_index)));
            check(32'(pixel_index), sig_n % COLS);
            check(32'(line_index), sig_n / COLS);
            ref_pend = 1'b0;
            sig_n++;
        end
    end
    // A start raised in mid-frame must leave no trace once the frame ends.
    task automatic frame(input logic [31:0] exp_len, input bit sneak);
        int l0, p0, k;
        l0 = lines_out;
        p0 = pix_out;
        shut_n = 0;
        sig_n = 0;
        ref_pend = 1'b0;
        expose_cycles <= exp_len;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (k = 0; k < 40000 && frame_done !== 1'b1; k++) begin
            @(posedge clk);
            start <= sneak && k == 500;
        end
        check(32'(lines_out - l0), LNS);
        check(32'(pix_out - p0), LNS * COLS);
        check(32'(sig_n), LNS * COLS);
        check(32'(shut_n), exp_len + 32'(exp_len == 32'h0));
        repeat (20) @(posedge clk);
        check(32'(busy), 32'h0);
        $display("test frame exposure %0d ignored start %0d done", exp_len, sneak);
    endtask : frame
    task automatic mid_reset;
        sig_n = 0;
        ref_pend = 1'b0;
        expose_cycles <= 32'h10;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (700) @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        check({vertical_phase_one, vertical_phase_two, horizontal_phase_one, horizontal_phase_two, reset_gate,
               shutter_open, busy, frame_done, pixel_class}, {8'h20, CCD_CLS_DUMMY});
        resetn <= 1'b1;
        @(posedge clk);
        $display("test reset in mid-frame done");
    endtask : mid_reset
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        frame(32'h40, 1'b0);
        frame(32'h0, 1'b1);
        mid_reset();
        frame(32'h3, 1'b0);
        results();
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        results();
    end
endmodule : test_ccd_readout_sequencer
bind ccd_readout_sequencer ccd_readout_sequencer_sva u_ccd_readout_sequencer_sva (.clk, .resetn,
    .vertical_phase_one, .vertical_phase_two, .horizontal_phase_one, .horizontal_phase_two, .reset_gate,
    .shutter_open, .sample_ref, .sample_sig, .busy, .frame_done);
